//--- tbab_buffer.sv
// trigger block acquisition buffer manager
// Overview of operation
// - a block is created only on the start event; its scans are readable at once
// - each scan request returns the oldest scan and then discards it
// - no random access; blocks are consumed strictly in written order
// - a read advances the read pointer so the next scan is readable at once
// - positions are logical, trigger scan at 0, pre-trigger negative
// - each block descriptor costs memory, lowering warning and overrun thresholds
// - one trigger per block; blocks stored back to back
// - re-arm only after the block completes; arm command needed without auto re-arm
// - auto re-arm acquires each trigger, rejects configuration; arm with flag 0 ends it
// - a trigger before the acquisition completes flags trigger overrun
// - status query answerable at any time, eight values
// - first field counts triggered blocks, zero when none
// - second field counts readable scans, pre-trigger excluded until triggered
// - third field is signed read position, undefined value when none
// - fourth field is trigger time stamp of current block, zero before trigger
// - fifth field is stop position, undefined until stop
// - sixth field is stop time stamp, zero until stop
// - seventh field is end position, stop plus post-stop count, undefined until end
// - eighth field is block state: acquiring, complete, or terminated by user
// - the block being read is number 1, the written one equals the count
// - the read pointer sits in the oldest unread block; status describes it
`include "tbab_map.svh"
`default_nettype none
module tbab_buffer #(
	parameter int DW = 32,
	parameter int AW = 10,
	parameter int BW = 3
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scanValid,
	input wire logic [DW-1:0] scanData,
	input wire logic startEvent,
	input wire logic stopEvent,
	input wire logic userAbort,
	input wire logic [47:0] rtcStamp,
	input wire logic armCmd,
	input wire logic armAuto,
	input wire logic cfgWrite,
	input wire logic [15:0] preCount,
	input wire logic [15:0] postStopCount,
	input wire logic readOneScan,
	input wire logic bufferStatusQuery,
	output logic scanOutValid,
	output logic [DW-1:0] scanOut,
	output logic readConflict,
	output logic cfgRejected,
	output logic trigOverrun,
	output logic fillWarn,
	output logic bufOverrun,
	output logic statusValid,
	output logic [31:0] stBlocks,
	output logic [31:0] stScans,
	output tbab_pkg::tbab_ptr_type stReadPtr,
	output tbab_pkg::tbab_stamp_type stTrigStamp,
	output tbab_pkg::tbab_ptr_type stStopPtr,
	output tbab_pkg::tbab_stamp_type stStopStamp,
	output tbab_pkg::tbab_ptr_type stEndPtr,
	output logic [1:0] stBlockState
);
	import tbab_pkg::*;
	localparam int NB = 1 << BW;
	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
	logic rstSync1_ff, rstSync2_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1_ff <= 1'b0;
			rstSync2_ff <= 1'b0;
		end else begin
			rstSync1_ff <= 1'b1;
			rstSync2_ff <= rstSync1_ff;
		end
	end
	wire logic rstN = rstSync2_ff;
	// block descriptors, one per slot of a small ring
	logic [AW-1:0] dBase_ff [0:NB-1];
	logic [31:0] dPre_ff [0:NB-1];
	logic [31:0] dLen_ff [0:NB-1];
	logic [31:0] dStop_ff [0:NB-1];
	logic [31:0] dEnd_ff [0:NB-1];
	logic dHasStop_ff [0:NB-1];
	logic dHasEnd_ff [0:NB-1];
	logic [1:0] dState_ff [0:NB-1];
	tbab_stamp_type dTrigT_ff [0:NB-1];
	tbab_stamp_type dStopT_ff [0:NB-1];
	logic [BW-1:0] rdBlk_ff, wrBlk_ff;
	logic [BW:0] blkCount_ff;
	logic [AW-1:0] wrAddr_ff, rdAddr_ff;
	logic [AW:0] used_ff, preFill_ff;
	logic [31:0] rdIdx_ff, scansAvail_ff;
	tbab_acq_type acq_ff;
	logic armed_ff, autoMode_ff;
	function automatic logic [AW:0] descCost(input logic [BW:0] n);
		descCost = (AW+1)'(n) * (AW+1)'(`TBAB_DESC_COST);
	endfunction
	function automatic tbab_ptr_type toLogical(input logic [31:0] idx, input logic [31:0] pre);
		toLogical = $signed(idx) - $signed(pre);
	endfunction
	wire logic [AW:0] occupied = used_ff + descCost(blkCount_ff);
	wire logic memFull = occupied >= DEPTH;
	wire logic rdBlkDone = dState_ff[rdBlk_ff] != `TBAB_STAT_ACQ;
	wire logic rdAtEnd = rdIdx_ff >= dLen_ff[rdBlk_ff];
	wire logic rdLast = (blkCount_ff > 1) && rdBlkDone && (rdIdx_ff + 32'h1 >= dLen_ff[rdBlk_ff]);
	wire logic rdOk = (blkCount_ff != 0) && !rdAtEnd;
	wire logic doRead = readOneScan && rdOk;
	wire logic isCur = blkCount_ff != 0;
	wire logic trigNow = startEvent && armed_ff && acq_ff == ACQ_PRE;
	wire logic writeScan = scanValid && !memFull && acq_ff != ACQ_IDLE;
	wire logic preWrite = writeScan && acq_ff == ACQ_PRE && !trigNow;
	wire logic [15:0] preUse = 16'(preFill_ff) < preCount ? 16'(preFill_ff) : preCount;
	logic [DW-1:0] memRd;
	tbab_scan_mem #(.DW(DW), .AW(AW)) uMem (
		.clk(clk),
		.wrEn(writeScan),
		.wrAddr(wrAddr_ff),
		.wrData(scanData),
		.rdAddr(rdAddr_ff),
		.rdData(memRd)
	);
	// arm and re-arm control
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			armed_ff <= 1'b0;
			autoMode_ff <= 1'b0;
		end else if (armCmd) begin
			armed_ff <= armAuto || acq_ff == ACQ_IDLE;
			autoMode_ff <= armAuto;
		end else if (trigNow) begin
			armed_ff <= 1'b0;
		end else if (acq_ff == ACQ_IDLE && autoMode_ff) begin
			armed_ff <= 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cfgRejected <= 1'b0;
			trigOverrun <= 1'b0;
			fillWarn <= 1'b0;
			bufOverrun <= 1'b0;
		end else begin
			cfgRejected <= cfgWrite && autoMode_ff;
			trigOverrun <= startEvent && (acq_ff == ACQ_POST || acq_ff == ACQ_PSTOP);
			fillWarn <= (AW+3)'(occupied) * (AW+3)'(`TBAB_WARN_DEN)
				>= (AW+3)'(DEPTH) * (AW+3)'(`TBAB_WARN_NUM);
			bufOverrun <= scanValid && memFull && acq_ff != ACQ_IDLE;
		end
	end
	// acquisition sequence on the write side
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			acq_ff <= ACQ_IDLE;
			wrBlk_ff <= '0;
			wrAddr_ff <= '0;
			preFill_ff <= '0;
		end else begin
			if (writeScan) begin
				wrAddr_ff <= wrAddr_ff + 1'b1;
			end
			case (acq_ff)
				ACQ_IDLE: begin
					preFill_ff <= '0;
					if (armed_ff) begin
						acq_ff <= ACQ_PRE;
					end
				end
				ACQ_PRE: begin
					if (trigNow) begin
						acq_ff <= ACQ_POST;
						preFill_ff <= '0;
					end else if (preWrite) begin
						preFill_ff <= preFill_ff + 1'b1;
					end
				end
				ACQ_POST: begin
					if (userAbort) begin
						acq_ff <= ACQ_IDLE;
						wrBlk_ff <= wrBlk_ff + 1'b1;
					end else if (stopEvent) begin
						acq_ff <= postStopCount == 0 ? ACQ_IDLE : ACQ_PSTOP;
						if (postStopCount == 0) begin
							wrBlk_ff <= wrBlk_ff + 1'b1;
						end
					end
				end
				ACQ_PSTOP: begin
					if (userAbort || (writeScan &&
						dLen_ff[wrBlk_ff] + 32'h1 >= dEnd_ff[wrBlk_ff] + dPre_ff[wrBlk_ff] + 32'h1)) begin
						acq_ff <= ACQ_IDLE;
						wrBlk_ff <= wrBlk_ff + 1'b1;
					end
				end
				default: acq_ff <= ACQ_IDLE;
			endcase
		end
	end
	// descriptor upkeep; logical positions count from the trigger scan
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < NB; i++) begin
				dBase_ff[i] <= '0;
				dPre_ff[i] <= '0;
				dLen_ff[i] <= '0;
				dStop_ff[i] <= '0;
				dEnd_ff[i] <= '0;
				dHasStop_ff[i] <= 1'b0;
				dHasEnd_ff[i] <= 1'b0;
				dState_ff[i] <= `TBAB_STAT_ACQ;
				dTrigT_ff[i] <= `TBAB_STAMP_ZERO;
				dStopT_ff[i] <= `TBAB_STAMP_ZERO;
			end
		end else begin
			if (trigNow) begin
				// pre-trigger scans beyond the configured count are dropped off the front
				dBase_ff[wrBlk_ff] <= wrAddr_ff - AW'(preUse);
				dPre_ff[wrBlk_ff] <= 32'(preUse);
				dLen_ff[wrBlk_ff] <= 32'(preUse) + (writeScan ? 32'h1 : 32'h0);
				dHasStop_ff[wrBlk_ff] <= 1'b0;
				dHasEnd_ff[wrBlk_ff] <= 1'b0;
				dState_ff[wrBlk_ff] <= `TBAB_STAT_ACQ;
				dTrigT_ff[wrBlk_ff] <= rtcStamp;
				dStopT_ff[wrBlk_ff] <= `TBAB_STAMP_ZERO;
			end else if (writeScan && acq_ff != ACQ_PRE) begin
				dLen_ff[wrBlk_ff] <= dLen_ff[wrBlk_ff] + 32'h1;
			end
			if (acq_ff == ACQ_POST && (stopEvent || userAbort)) begin
				dHasStop_ff[wrBlk_ff] <= 1'b1;
				dStop_ff[wrBlk_ff] <= dLen_ff[wrBlk_ff] - dPre_ff[wrBlk_ff];
				dStopT_ff[wrBlk_ff] <= rtcStamp;
				dEnd_ff[wrBlk_ff] <= dLen_ff[wrBlk_ff] - dPre_ff[wrBlk_ff] + 32'(postStopCount);
				if (userAbort || postStopCount == 0) begin
					dHasEnd_ff[wrBlk_ff] <= 1'b1;
					dState_ff[wrBlk_ff] <= userAbort ? `TBAB_STAT_ABORT : `TBAB_STAT_DONE;
				end
			end
			if (acq_ff == ACQ_PSTOP && (userAbort || (writeScan &&
				dLen_ff[wrBlk_ff] + 32'h1 >= dEnd_ff[wrBlk_ff] + dPre_ff[wrBlk_ff] + 32'h1))) begin
				dHasEnd_ff[wrBlk_ff] <= 1'b1;
				dState_ff[wrBlk_ff] <= userAbort ? `TBAB_STAT_ABORT : `TBAB_STAT_DONE;
			end
		end
	end
	// read side: strictly oldest first, no seek
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rdBlk_ff <= '0;
			rdIdx_ff <= '0;
			rdAddr_ff <= '0;
			scanOutValid <= 1'b0;
			scanOut <= '0;
			readConflict <= 1'b0;
		end else begin
			scanOutValid <= doRead;
			readConflict <= readOneScan && !rdOk;
			if (doRead) begin
				scanOut <= memRd;
			end
			if (trigNow && blkCount_ff == 0) begin
				rdAddr_ff <= wrAddr_ff - AW'(preUse);
				rdIdx_ff <= '0;
			end else if (doRead) begin
				if (rdLast) begin
					rdBlk_ff <= rdBlk_ff + 1'b1;
					rdIdx_ff <= '0;
					rdAddr_ff <= dBase_ff[rdBlk_ff + 1'b1];
				end else begin
					rdIdx_ff <= rdIdx_ff + 32'h1;
					rdAddr_ff <= rdAddr_ff + 1'b1;
				end
			end
		end
	end
	// occupancy and counts
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			blkCount_ff <= '0;
			used_ff <= '0;
			scansAvail_ff <= '0;
		end else begin
			blkCount_ff <= blkCount_ff + (trigNow ? 1'b1 : 1'b0) - ((doRead && rdLast) ? 1'b1 : 1'b0);
			used_ff <= used_ff + (writeScan ? 1'b1 : 1'b0) - (doRead ? 1'b1 : 1'b0)
				- ((trigNow ? preFill_ff - (AW+1)'(preUse) : '0)) - (acq_ff == ACQ_IDLE ? preFill_ff : '0);
			// pre-trigger scans join the total only at the trigger
			scansAvail_ff <= scansAvail_ff + (trigNow ? 32'(preUse) : 32'h0)
				+ ((writeScan && (acq_ff != ACQ_PRE || trigNow)) ? 32'h1 : 32'h0) - (doRead ? 32'h1 : 32'h0);
		end
	end
	// status reply registers; a query only samples, it never alters state
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			statusValid <= 1'b0;
			stBlocks <= '0;
			stScans <= '0;
			stReadPtr <= `TBAB_PTR_UNDEF;
			stTrigStamp <= `TBAB_STAMP_ZERO;
			stStopPtr <= `TBAB_PTR_UNDEF;
			stStopStamp <= `TBAB_STAMP_ZERO;
			stEndPtr <= `TBAB_PTR_UNDEF;
			stBlockState <= `TBAB_STAT_ACQ;
		end else begin
			statusValid <= bufferStatusQuery;
			if (bufferStatusQuery) begin
				stBlocks <= 32'(blkCount_ff);
				stScans <= scansAvail_ff;
				stReadPtr <= rdOk ? toLogical(rdIdx_ff, dPre_ff[rdBlk_ff]) : `TBAB_PTR_UNDEF;
				stTrigStamp <= isCur ? dTrigT_ff[rdBlk_ff] : `TBAB_STAMP_ZERO;
				stStopPtr <= (isCur && dHasStop_ff[rdBlk_ff]) ? dStop_ff[rdBlk_ff] : `TBAB_PTR_UNDEF;
				stStopStamp <= (isCur && dHasStop_ff[rdBlk_ff]) ? dStopT_ff[rdBlk_ff] : `TBAB_STAMP_ZERO;
				stEndPtr <= (isCur && dHasEnd_ff[rdBlk_ff]) ? dEnd_ff[rdBlk_ff] : `TBAB_PTR_UNDEF;
				stBlockState <= isCur ? dState_ff[rdBlk_ff] : `TBAB_STAT_ACQ;
			end
		end
	end
endmodule // tbab_buffer
`default_nettype wire

//--- tbab_buffer_monitor.sv
// port-level assertions for the acquisition buffer manager
`include "tbab_map.svh"
`default_nettype none
module tbab_check (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic readOneScan,
	input wire logic bufferStatusQuery,
	input wire logic cfgWrite,
	input wire logic scanOutValid,
	input wire logic readConflict,
	input wire logic cfgRejected,
	input wire logic statusValid,
	input wire logic [31:0] stBlocks,
	input wire logic [31:0] stScans,
	input wire tbab_pkg::tbab_ptr_type stReadPtr,
	input wire tbab_pkg::tbab_stamp_type stTrigStamp,
	input wire tbab_pkg::tbab_ptr_type stStopPtr,
	input wire tbab_pkg::tbab_stamp_type stStopStamp,
	input wire tbab_pkg::tbab_ptr_type stEndPtr,
	input wire logic [1:0] stBlockState
);
	timeunit 1ns;
	timeprecision 1ps;
	import tbab_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence sReq; readOneScan; endsequence
	sequence sAns; scanOutValid ^ readConflict; endsequence
	AST_READ_ANSWER: assert property (sReq |=> sAns) else $error("read got no answer");
	AST_READ_CAUSE: assert property (sAns |-> $past(readOneScan)) else $error("answer without read");
	AST_STAT_ANSWER: assert property (bufferStatusQuery |=> statusValid) else $error("query unanswered");
	AST_STAT_CAUSE: assert property (statusValid |-> $past(bufferStatusQuery)) else $error("stray status");
	AST_STAT_HOLD: assert property (!statusValid |-> $stable(stReadPtr) && $stable(stScans) && $stable(stBlocks))
		else $error("status fields moved without query");
	AST_CFG_REJ: assert property (cfgRejected |-> $past(cfgWrite)) else $error("reject without write");
	AST_EMPTY: assert property (statusValid && stBlocks == 0 |-> stScans == 0 &&
		stReadPtr == `TBAB_PTR_UNDEF && stTrigStamp == `TBAB_STAMP_ZERO) else $error("empty status wrong");
	AST_STOP_STAMP: assert property (statusValid && stStopPtr == `TBAB_PTR_UNDEF |->
		stStopStamp == `TBAB_STAMP_ZERO) else $error("stop stamp before stop");
	AST_END_STOP: assert property (statusValid && stEndPtr != `TBAB_PTR_UNDEF |->
		stEndPtr >= stStopPtr && stStopPtr > 0) else $error("end before stop");
	AST_DONE_END: assert property (statusValid && stBlockState == `TBAB_STAT_DONE |->
		stEndPtr != `TBAB_PTR_UNDEF) else $error("done without end");
	AST_PTR_BLOCK: assert property (statusValid && stReadPtr != `TBAB_PTR_UNDEF |-> stBlocks != 0)
		else $error("read pointer without block");
endmodule // tbab_check
`default_nettype wire

//--- tbab_host.sv
// host controller model: scan reads, status queries and arm commands
`default_nettype none
module tbab_host #(
	parameter int DW = 32
) (
	input wire logic clk,
	output logic readOneScan,
	output logic bufferStatusQuery,
	output logic armCmd,
	output logic armAuto,
	input wire logic scanOutValid,
	input wire logic [DW-1:0] scanOut,
	input wire logic readConflict,
	input wire logic statusValid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		readOneScan = 1'b0;
		bufferStatusQuery = 1'b0;
		armCmd = 1'b0;
		armAuto = 1'b0;
	end
	// the answer stands only in the cycle after the taking edge, so sample it at the falling edge inside it
	task automatic read_scan(output logic [DW-1:0] d, output logic v, output logic c);
		@(negedge clk);
		readOneScan = 1'b1;
		@(negedge clk);
		d = scanOut;
		v = scanOutValid;
		c = readConflict;
		readOneScan = 1'b0;
	endtask
	task automatic query(output logic v);
		@(negedge clk);
		bufferStatusQuery = 1'b1;
		@(negedge clk);
		v = statusValid;
		bufferStatusQuery = 1'b0;
	endtask
	// flag held after the pulse; a zero flag ends auto re-arm
	task automatic arm(input logic auto);
		@(negedge clk);
		armAuto = auto;
		armCmd = 1'b1;
		@(negedge clk);
		armCmd = 1'b0;
	endtask
endmodule // tbab_host
`default_nettype wire

//--- tbab_map.svh
// constants for the trigger block acquisition buffer
`ifndef TBAB_MAP_SVH
`define TBAB_MAP_SVH
`define TBAB_PTR_UNDEF 32'hfff0bdc1
`define TBAB_STAT_ACQ 2'h0
`define TBAB_STAT_DONE 2'h1
`define TBAB_STAT_ABORT 2'h2
`define TBAB_WARN_NUM 4'h3
`define TBAB_WARN_DEN 4'h4
`define TBAB_DESC_COST 16'h0004
`define TBAB_STAMP_ZERO 48'h000000000000
`endif

//--- tbab_pkg.sv
// types for the trigger block acquisition buffer
`default_nettype none
package tbab_pkg;
	typedef enum {ACQ_IDLE, ACQ_PRE, ACQ_POST, ACQ_PSTOP} tbab_acq_type;
	typedef logic [47:0] tbab_stamp_type;
	typedef logic signed [31:0] tbab_ptr_type;
endpackage
`default_nettype wire

//--- tbab_scan_mem.sv
// circular scan storage
`default_nettype none
module tbab_scan_mem #(
	parameter int DW = 32,
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [DW-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end
	assign rdData = mem[rdAddr];
endmodule // tbab_scan_mem
`default_nettype wire

//--- test_trigger_block_acquisition_buffer.sv
// self-checking bench for the acquisition buffer manager
`include "tbab_map.svh"
`default_nettype none
module test_trigger_block_acquisition_buffer;
	timeunit 1ns;
	timeprecision 1ps;
	import tbab_pkg::*;
	localparam tbab_ptr_type UNDEF = `TBAB_PTR_UNDEF;
	localparam tbab_stamp_type TS1 = 48'h000012345678;
	localparam tbab_stamp_type TS2 = 48'h00009abcdef0;
	logic clk = 0, arst_n = 0, scanValid = 0, startEvent = 0, stopEvent = 0, userAbort = 0, cfgWrite = 0;
	logic [31:0] scanData = 32'h0;
	logic [47:0] rtcStamp = 48'h0;
	logic [15:0] preCount = 16'h2, postStopCount = 16'h1;
	logic readOneScan, bufferStatusQuery, armCmd, armAuto, scanOutValid, readConflict, cfgRejected, trigOverrun;
	logic fillWarn, bufOverrun, statusValid, v, c;
	logic [31:0] scanOut, stBlocks, stScans, d;
	tbab_ptr_type stReadPtr, stStopPtr, stEndPtr;
	tbab_stamp_type stTrigStamp, stStopStamp;
	logic [1:0] stBlockState;
	int failures = 0, checks_done = 0, nOvr = 0, nRej = 0, nBov = 0;
	tbab_buffer i_dut (.clk, .arst_n, .scanValid, .scanData, .startEvent, .stopEvent, .userAbort, .rtcStamp,
		.armCmd, .armAuto, .cfgWrite, .preCount, .postStopCount, .readOneScan, .bufferStatusQuery,
		.scanOutValid, .scanOut, .readConflict, .cfgRejected, .trigOverrun, .fillWarn, .bufOverrun,
		.statusValid, .stBlocks, .stScans, .stReadPtr, .stTrigStamp, .stStopPtr, .stStopStamp, .stEndPtr,
		.stBlockState);
	tbab_host i_host (.clk, .readOneScan, .bufferStatusQuery, .armCmd, .armAuto, .scanOutValid, .scanOut,
		.readConflict, .statusValid);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (trigOverrun) nOvr <= nOvr + 1;
		if (cfgRejected) nRej <= nRej + 1;
		if (bufOverrun) nBov <= nBov + 1;
	end
	task automatic check(input string n, input logic [47:0] exp, input logic [47:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	// two flops re-time the release, so wait three edges before any request
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		pulse(cfgWrite);
	endtask
	task automatic scan(input logic [31:0] dat, input logic st, input logic sp);
		@(negedge clk);
		scanValid = 1'b1;
		scanData = dat;
		startEvent = st;
		stopEvent = sp;
		@(negedge clk);
		scanValid = 1'b0;
		startEvent = 1'b0;
		stopEvent = 1'b0;
	endtask
	task automatic rd(input logic [31:0] exp);
		i_host.read_scan(d, v, c);
		check("scanOutValid", 1'b1, v);
		check("scanOut", exp, d);
	endtask
	task automatic status(input logic [31:0] b, s, input tbab_ptr_type rp, sp, ep, input tbab_stamp_type ts, ss,
		input logic [1:0] bs);
		i_host.query(v);
		check("statusValid", 1'b1, v);
		check("stBlocks", b, stBlocks);
		check("stScans", s, stScans);
		check("stReadPtr", rp, stReadPtr);
		check("stTrigStamp", ts, stTrigStamp);
		check("stStopPtr", sp, stStopPtr);
		check("stStopStamp", ss, stStopStamp);
		check("stEndPtr", ep, stEndPtr);
		check("stBlockState", bs, stBlockState);
	endtask
	task automatic t_single();
		status(0, 0, UNDEF, UNDEF, UNDEF, 0, 0, `TBAB_STAT_ACQ);
		i_host.read_scan(d, v, c);
		check("readConflict", 1'b1, c);
		i_host.arm(1'b0);
		scan(32'h10, 0, 0);
		scan(32'h11, 0, 0);
		status(0, 0, UNDEF, UNDEF, UNDEF, 0, 0, `TBAB_STAT_ACQ);
		rtcStamp = TS1;
		scan(32'h20, 1, 0);
		status(1, 3, -2, UNDEF, UNDEF, TS1, 0, `TBAB_STAT_ACQ);
		rd(32'h10);
		status(1, 2, -1, UNDEF, UNDEF, TS1, 0, `TBAB_STAT_ACQ);
		status(1, 2, -1, UNDEF, UNDEF, TS1, 0, `TBAB_STAT_ACQ);
		scan(32'h21, 1, 0);
		@(negedge clk);
		check("trigOverrun", 1'b1, nOvr != 0);
		rtcStamp = TS2;
		scan(32'h22, 0, 1);
		scan(32'h23, 0, 0);
		scan(32'h40, 1, 0);
		status(1, 5, -1, 2, 3, TS1, TS2, `TBAB_STAT_DONE);
		for (int i = 0; i < 5; i++) rd(i == 0 ? 32'h11 : 32'h1f + i);
		i_host.read_scan(d, v, c);
		check("readConflict", 1'b1, c);
	endtask
	task automatic t_auto();
		int r;
		do_reset();
		i_host.arm(1'b1);
		r = nRej;
		pulse(cfgWrite);
		@(negedge clk);
		check("cfgRejected", 1'b1, nRej != r);
		for (int b = 0; b < 2; b++) begin
			rtcStamp = b ? TS2 : TS1;
			for (int k = 0; k < 5; k++) scan(32'h50 + 16 * b + k, k == 2, k == 3);
			// re-arm passes through idle, where scans are ignored; let it reach pre-trigger first
			repeat (2) @(negedge clk);
		end
		status(2, 10, -2, 1, 2, TS1, TS1, `TBAB_STAT_DONE);
		for (int k = 0; k < 10; k++) rd(32'h50 + 16 * (k / 5) + k % 5);
		i_host.arm(1'b0);
		r = nRej;
		pulse(cfgWrite);
		@(negedge clk);
		check("cfgRejected", 1'b0, nRej != r);
	endtask
	task automatic t_abort();
		do_reset();
		i_host.arm(1'b0);
		scan(32'h60, 0, 0);
		scan(32'h61, 0, 0);
		rtcStamp = TS1;
		scan(32'h62, 1, 0);
		pulse(userAbort);
		status(1, 3, -2, 1, 2, TS1, TS1, `TBAB_STAT_ABORT);
		check("fillWarn", 1'b0, fillWarn);
	endtask
	// one block: warning at three quarters of the depth less one descriptor, overrun once full
	task automatic t_fill();
		int n;
		n = `TBAB_WARN_NUM * (1 << 10) / `TBAB_WARN_DEN - `TBAB_DESC_COST;
		do_reset();
		i_host.arm(1'b0);
		scan(32'h70, 1, 0);
		for (int k = 1; k < n - 1; k++) scan(k, 0, 0);
		@(negedge clk);
		check("fillWarn", 1'b0, fillWarn);
		scan(32'h71, 0, 0);
		@(negedge clk);
		check("fillWarn", 1'b1, fillWarn);
		for (int k = n; k < (1 << 10) - `TBAB_DESC_COST; k++) scan(k, 0, 0);
		@(negedge clk);
		check("bufOverrun", 1'b0, nBov != 0);
		scan(32'h72, 0, 0);
		@(negedge clk);
		check("bufOverrun", 1'b1, nBov != 0);
	endtask
	initial begin
		#200us;
		failures++;
		wrap_up();
	end
	initial begin
		do_reset();
		t_single();
		t_auto();
		t_abort();
		t_fill();
		wrap_up();
	end
endmodule // test_trigger_block_acquisition_buffer
bind tbab_buffer tbab_check u_check (.clk, .arst_n, .readOneScan, .bufferStatusQuery, .cfgWrite, .scanOutValid,
	.readConflict, .cfgRejected, .statusValid, .stBlocks, .stScans, .stReadPtr, .stTrigStamp, .stStopPtr,
	.stStopStamp, .stEndPtr, .stBlockState);
`default_nettype wire
